/* File: hw/envs_mem.sv */
// Word memory with page clear and registered read data
`timescale 1ns/10ps
module envs_mem (
	input  wire logic                          core_clk_i,
	input  wire logic                          ce_i,
	input  wire logic                          we_i,
	input  wire logic                          clr_i,
	input  wire logic                          page_i,
	input  wire logic [envs_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [envs_pkg::WORD_W-1:0]   wdata_i,
	output logic      [envs_pkg::WORD_W-1:0]   rdata_o
);
	import envs_pkg::*;
	logic [WORD_W-1:0] mem_r [WORDS];

	genvar g;
	generate
		for (g = 0; g < WORDS; g++) begin : g_word
			always_ff @(posedge core_clk_i) begin
				if (ce_i) begin
					if (clr_i && (g / PAGE_WORDS == int'(page_i)))
						mem_r[g] <= '0;
					else if (we_i && addr_i == ADDR_W'(g))
						mem_r[g] <= wdata_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (ce_i)
			rdata_o <= mem_r[addr_i];
	end
endmodule : envs_mem

/* File: hw/envs_pkg.sv */
// Constants for the emulated non-volatile word store
package envs_pkg;
	localparam int unsigned CLK_MHZ       = 125;
	localparam logic [1:0]  OFS_ADDRESS   = 2'h0;
	localparam logic [1:0]  OFS_DATA_LOW  = 2'h1;
	localparam logic [1:0]  OFS_DATA_HIGH = 2'h2;
	localparam logic [1:0]  OFS_CONTROL   = 2'h3;
	localparam int unsigned WORDS         = 32;
	localparam int unsigned WORD_W        = 14;
	localparam int unsigned ADDR_W        = 5;
	localparam int unsigned PAGE_WORDS    = 16;
	localparam logic [7:0]  RST_REG       = 8'h00;
	localparam int unsigned BIT_RD_START  = 0;
	localparam int unsigned BIT_RD_EN     = 1;
	localparam int unsigned BIT_WR_START  = 2;
	localparam int unsigned BIT_WR_EN     = 3;
	localparam int unsigned BIT_ER_START  = 4;
	localparam int unsigned BIT_ER_EN     = 5;
	localparam int unsigned BIT_TSEL_LO   = 6;
	localparam int unsigned PROG_MS_BASE  = 2;
	localparam int unsigned PROG_CYC_BASE = PROG_MS_BASE * 1000 * CLK_MHZ;
	localparam int unsigned READ_CYCLES   = 2;
	localparam int unsigned CNT_W         = 22;
	typedef enum logic [1:0] {
		ENVS_IDLE, ENVS_ERASE, ENVS_WRITE, ENVS_READ
	} envs_state_type;
endpackage : envs_pkg

/* File: hw/envs_top.sv */
// Emulated non-volatile word store controller with register port
`timescale 1ns/10ps
module envs_top #(
	parameter int unsigned PROG_CYCLES = envs_pkg::PROG_CYC_BASE
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	input  wire logic [1:0]          reg_addr_i,
	input  wire logic [7:0]          reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [7:0]          reg_rdata_o,
	output logic                     cpu_stall_o
);
	import envs_pkg::*;

	logic [ADDR_W-1:0]  addr_r;
	logic [7:0]         data_lo_r;
	logic [5:0]         data_hi_r;
	logic [1:0]         tsel_r;
	logic               er_en_r, er_st_r, wr_en_r, wr_st_r;
	logic               rd_en_r, rd_st_r;
	logic               en_wr_last_r;
	envs_state_type     state_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [CNT_W-1:0]   cnt_load;
	logic [WORD_W-1:0]  mem_rdata;
	logic               ctl_wr, go_erase, go_write, go_read, done;
	logic               mem_we, mem_clr, rd_capture_r;

	assign ctl_wr = reg_wr_i && reg_addr_i == OFS_CONTROL;
	assign go_erase = ctl_wr && state_r == ENVS_IDLE && en_wr_last_r
		&& er_en_r && reg_wdata_i[BIT_ER_START];
	assign go_write = ctl_wr && state_r == ENVS_IDLE && en_wr_last_r
		&& wr_en_r && reg_wdata_i[BIT_WR_START] && !go_erase;
	assign go_read = ctl_wr && state_r == ENVS_IDLE && rd_en_r
		&& reg_wdata_i[BIT_RD_START] && !go_erase && !go_write;
	assign done = state_r != ENVS_IDLE && cnt_r == '0;
	assign cnt_load = CNT_W'((PROG_CYCLES << tsel_r) - 1);
	assign mem_we  = ce_i && done && state_r == ENVS_WRITE;
	assign mem_clr = ce_i && done && state_r == ENVS_ERASE;

	// Enable-set tracking: erase or write may start only on the very next register access, reads included
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			en_wr_last_r <= 1'b0;
		else if (ce_i && (reg_wr_i || reg_rd_i))
			en_wr_last_r <= ctl_wr && (
				(reg_wdata_i[BIT_ER_EN] && !er_en_r) ||
				(reg_wdata_i[BIT_WR_EN] && !wr_en_r));
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			addr_r <= '0;
		else if (ce_i && reg_wr_i && reg_addr_i == OFS_ADDRESS)
			addr_r <= reg_wdata_i[ADDR_W-1:0];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			data_lo_r <= RST_REG;
			data_hi_r <= '0;
		end else if (ce_i) begin
			if (rd_capture_r) begin
				data_lo_r <= mem_rdata[7:0];
				data_hi_r <= mem_rdata[13:8];
			end else if (reg_wr_i && reg_addr_i == OFS_DATA_LOW)
				data_lo_r <= reg_wdata_i;
			else if (reg_wr_i && reg_addr_i == OFS_DATA_HIGH)
				data_hi_r <= reg_wdata_i[5:0];
		end
	end

	// Control register; hardware clears win over software writes
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tsel_r  <= '0;
			er_en_r <= 1'b0;
			er_st_r <= 1'b0;
			wr_en_r <= 1'b0;
			wr_st_r <= 1'b0;
			rd_en_r <= 1'b0;
			rd_st_r <= 1'b0;
		end else if (ce_i) begin
			if (ctl_wr && state_r == ENVS_IDLE) begin
				tsel_r  <= reg_wdata_i[BIT_TSEL_LO +: 2];
				er_en_r <= reg_wdata_i[BIT_ER_EN];
				wr_en_r <= reg_wdata_i[BIT_WR_EN];
				rd_en_r <= reg_wdata_i[BIT_RD_EN];
				er_st_r <= go_erase;
				wr_st_r <= go_write;
				rd_st_r <= go_read;
			end
			if (done) begin
				case (state_r)
					ENVS_ERASE: begin
						er_en_r <= 1'b0;
						er_st_r <= 1'b0;
					end
					ENVS_WRITE: begin
						wr_en_r <= 1'b0;
						wr_st_r <= 1'b0;
					end
					ENVS_READ: rd_st_r <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r      <= ENVS_IDLE;
			cnt_r        <= '0;
			cpu_stall_o  <= 1'b0;
			rd_capture_r <= 1'b0;
		end else if (ce_i) begin
			rd_capture_r <= done && state_r == ENVS_READ;
			case (state_r)
				ENVS_IDLE: begin
					if (go_erase || go_write) begin
						state_r     <= go_erase ? ENVS_ERASE : ENVS_WRITE;
						cnt_r       <= cnt_load;
						cpu_stall_o <= 1'b1;
					end else if (go_read) begin
						state_r     <= ENVS_READ;
						cnt_r       <= CNT_W'(READ_CYCLES - 1);
						cpu_stall_o <= 1'b1;
					end
				end
				ENVS_ERASE, ENVS_WRITE, ENVS_READ: begin
					if (cnt_r == '0) begin
						state_r     <= ENVS_IDLE;
						cpu_stall_o <= 1'b0;
					end else
						cnt_r <= cnt_r - 1'b1;
				end
				default: state_r <= ENVS_IDLE;
			endcase
		end
	end

	envs_mem u_mem (
		.core_clk_i (core_clk_i),
		.ce_i       (ce_i),
		.we_i       (mem_we),
		.clr_i      (mem_clr),
		.page_i     (addr_r[ADDR_W-1]),
		.addr_i     (addr_r),
		.wdata_i    ({data_hi_r, data_lo_r}),
		.rdata_o    (mem_rdata)
	);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			reg_rdata_o <= RST_REG;
		else if (ce_i) begin
			case (reg_addr_i)
				OFS_ADDRESS:   reg_rdata_o <= {3'h0, addr_r};
				OFS_DATA_LOW:  reg_rdata_o <= data_lo_r;
				OFS_DATA_HIGH: reg_rdata_o <= {2'h0, data_hi_r};
				OFS_CONTROL:   reg_rdata_o <= {tsel_r, er_en_r, er_st_r,
					wr_en_r, wr_st_r, rd_en_r, rd_st_r};
				default:       reg_rdata_o <= RST_REG;
			endcase
		end
	end

	property p_stall_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(state_r != ENVS_IDLE) |-> cpu_stall_o;
	endproperty
	a_stall_busy: assert property (p_stall_busy)
		else $error("stall low while busy");

	property p_er_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && done && state_r == ENVS_ERASE) |=> !er_en_r && !er_st_r;
	endproperty
	a_er_clear: assert property (p_er_clear)
		else $error("erase bits not cleared");

	property p_wr_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && done && state_r == ENVS_WRITE) |=> !wr_en_r && !wr_st_r;
	endproperty
	a_wr_clear: assert property (p_wr_clear)
		else $error("write bits not cleared");

	property p_rd_keep;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && done && state_r == ENVS_READ) |=> rd_en_r && !rd_st_r;
	endproperty
	a_rd_keep: assert property (p_rd_keep)
		else $error("read enable lost");

	property p_er_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(er_st_r) |-> $past(er_en_r);
	endproperty
	a_er_gate: assert property (p_er_gate)
		else $error("erase started without enable");

	property p_wr_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(wr_st_r) |-> $past(wr_en_r);
	endproperty
	a_wr_gate: assert property (p_wr_gate)
		else $error("write started without enable");

	property p_rd_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(rd_st_r) |-> $past(rd_en_r);
	endproperty
	a_rd_gate: assert property (p_rd_gate)
		else $error("read started without enable");

	property p_read_len;
		@(posedge core_clk_i) disable iff (!rst_n_i || !ce_i)
		(go_read && ce_i) |=> cpu_stall_o [*2] ##1 !cpu_stall_o;
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("read stall length wrong");

	property p_hi_zero;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		($past(reg_rd_i && ce_i && reg_addr_i == OFS_DATA_HIGH))
			|-> reg_rdata_o[7:6] == 2'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("high data top bits nonzero");

	// stall length counted apart from the sequencer
	logic [CNT_W:0] stall_len_r;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			stall_len_r <= '0;
		else if (ce_i)
			stall_len_r <= cpu_stall_o ? stall_len_r + 1'b1 : '0;
	end

	property p_prog_len;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && done && (state_r == ENVS_ERASE || state_r == ENVS_WRITE))
			|-> (32'(stall_len_r) + 32'h1) == (PROG_CYCLES << tsel_r);
	endproperty
	a_prog_len: assert property (p_prog_len)
		else $error("program stall length wrong");

	// no erase or write start unless the previous register access set an erase or write enable
	property p_gap_cancel;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ce_i && ctl_wr && state_r == ENVS_IDLE && !en_wr_last_r)
			|=> !er_st_r && !wr_st_r;
	endproperty
	a_gap_cancel: assert property (p_gap_cancel)
		else $error("start accepted without enable just before");

	c_erase: cover property (@(posedge core_clk_i) go_erase);
	c_write: cover property (@(posedge core_clk_i) go_write);
	c_read:  cover property (@(posedge core_clk_i) go_read);
	c_done:  cover property (@(posedge core_clk_i) done);
endmodule : envs_top

/* File: test/envs_cpu_model.sv */
// Processor model driving the register port and honouring stall
`timescale 1ns/10ps
module envs_cpu_model (
	input  wire logic       core_clk_i,
	input  wire logic       stall_i,
	input  wire logic [7:0] rdata_i,
	output logic      [1:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o
);
	initial begin
		reg_addr_o = 2'h0;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// Idle cycles flip data so a stale value never looks valid
	task automatic cyc(input logic w, input logic r, input logic [1:0] a,
		input logic [7:0] d);
		reg_wr_o <= w;
		reg_rd_o <= r;
		reg_addr_o <= a;
		reg_wdata_o <= w ? d : ~reg_wdata_o;
		@(posedge core_clk_i);
	endtask : cyc

	task automatic wr(input logic [1:0] a, input logic [7:0] d,
		output int n);
		cyc(1'b1, 1'b0, a, d);
		cyc(1'b0, 1'b0, a, d);
		n = 0;
		while (stall_i === 1'b1 && n < 1000) begin
			n++;
			@(posedge core_clk_i);
		end
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		cyc(1'b0, 1'b1, a, 8'h00);
		cyc(1'b0, 1'b0, a, 8'h00);
		v = rdata_i;
	endtask : rd

	task automatic prog(input logic [7:0] en, input logic [7:0] go,
		output int n);
		wr(envs_pkg::OFS_CONTROL, en, n);
		wr(envs_pkg::OFS_CONTROL, en | go, n);
	endtask : prog
endmodule : envs_cpu_model

/* File: test/envs_top_bench.sv */
// Self-checking bench for the non-volatile word store
`timescale 1ns/10ps
module envs_top_bench;
	import envs_pkg::*;
	localparam int unsigned SIM_PROG = 4;
	typedef struct packed {
		logic [1:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} envs_row_type;
	logic         core_clk_i;
	logic         rst_n_i;
	logic         ce_i;
	logic [1:0]   reg_addr_i;
	logic [7:0]   reg_wdata_i;
	logic         reg_wr_i;
	logic         reg_rd_i;
	logic [7:0]   reg_rdata_o;
	logic         cpu_stall_o;
	logic [7:0]   v;
	logic [7:0]   lone [3];
	int           errors;
	int           n_tests;
	int           n;
	envs_row_type rows [4];

	envs_top #(.PROG_CYCLES(SIM_PROG)) dut (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.cpu_stall_o(cpu_stall_o));
	envs_cpu_model cpu (.core_clk_i(core_clk_i), .stall_i(cpu_stall_o),
		.rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i));

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [1:0] a, input logic [7:0] e,
		input string s);
		cpu.rd(a, v);
		chk(s, {24'h0, e}, {24'h0, v});
	endtask : rchk

	task automatic ers(input logic [4:0] a, input logic [1:0] t);
		cpu.wr(OFS_ADDRESS, {3'h0, a}, n);
		cpu.prog({t, 6'h20}, 8'h10, n);
		chk("erase stall", SIM_PROG << t, n);
		rchk(OFS_CONTROL, {t, 6'h00}, "erase ctl");
	endtask : ers

	task automatic wword(input logic [4:0] a, input logic [13:0] w);
		cpu.wr(OFS_ADDRESS, {3'h0, a}, n);
		cpu.wr(OFS_DATA_LOW, w[7:0], n);
		cpu.wr(OFS_DATA_HIGH, {2'h0, w[13:8]}, n);
		cpu.prog(8'h08, 8'h04, n);
		chk("write stall", SIM_PROG, n);
		rchk(OFS_CONTROL, 8'h00, "write ctl");
	endtask : wword

	task automatic rword(input logic [4:0] a, input logic [13:0] e);
		cpu.wr(OFS_ADDRESS, {3'h0, a}, n);
		cpu.prog(8'h02, 8'h01, n);
		chk("read stall", READ_CYCLES, n);
		rchk(OFS_CONTROL, 8'h02, "read ctl");
		rchk(OFS_DATA_LOW, e[7:0], "data low");
		rchk(OFS_DATA_HIGH, {2'h0, e[13:8]}, "data high");
	endtask : rword

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// Whole run needs well under a thousand cycles
	initial begin
		#100000;
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		rows = '{'{OFS_ADDRESS, 8'hff, 8'h1f}, '{OFS_DATA_LOW, 8'ha5, 8'ha5},
			'{OFS_DATA_HIGH, 8'hff, 8'h3f}, '{OFS_CONTROL, 8'hc0, 8'hc0}};
		lone = '{8'h10, 8'h04, 8'h01};
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rchk(2'(i), RST_REG, "reset value");
		end
		foreach (rows[i]) begin
			cpu.wr(rows[i].a, rows[i].d, n);
			rchk(rows[i].a, rows[i].e, "readback");
		end
		for (int t = 0; t < 4; t++) begin
			ers(5'h00, 2'(t));
		end
		wword(5'h05, 14'h1234);
		rword(5'h05, 14'h1234);
		rword(5'h06, 14'h0000);
		ers(5'h10, 2'h0);
		wword(5'h13, 14'h2abc);
		rword(5'h13, 14'h2abc);
		ers(5'h1c, 2'h0);
		rword(5'h13, 14'h0000);
		// Strobe between enable and start cancels the write
		cpu.wr(OFS_CONTROL, 8'h08, n);
		cpu.wr(OFS_ADDRESS, 8'h05, n);
		cpu.wr(OFS_CONTROL, 8'h0c, n);
		chk("gap stall", 0, n);
		rword(5'h05, 14'h1234);
		foreach (lone[i]) begin
			cpu.wr(OFS_CONTROL, lone[i], n);
			chk("lone start", 0, n);
		end
		rchk(OFS_DATA_LOW, 8'h34, "held low");
		rchk(OFS_DATA_HIGH, 8'h12, "held high");
		// Clock enable low must drop a write
		ce_i <= 1'b0;
		cpu.wr(OFS_DATA_LOW, 8'h5a, n);
		ce_i <= 1'b1;
		rchk(OFS_DATA_LOW, 8'h34, "frozen write");
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rchk(OFS_ADDRESS, RST_REG, "second reset");
		rchk(OFS_DATA_LOW, RST_REG, "second reset");
		rchk(OFS_DATA_HIGH, RST_REG, "second reset");
		give_verdict();
	end
endmodule : envs_top_bench
